// ==== hdl/cag_access_guard.sv ====
// Register access guard between the CPU core and the register resources.
`timescale 1ns/1ns

module cag_access_guard (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic cpu_valid,
	input wire logic cpu_write,
	input wire logic [7:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	output logic [7:0] cpu_rdata,
	output logic cpu_denied,
	input wire logic seg_rd_ok,
	input wire logic seg_wr_ok,
	input wire logic irq_entry,
	input wire logic irq_return,
	input wire logic branch_valid,
	input wire logic branch_call,
	input wire logic [15:0] branch_target,
	output logic res_valid,
	output logic res_write,
	output logic [7:0] res_addr,
	output logic [7:0] res_wdata,
	input wire logic [7:0] res_rdata,
	output logic [15:0] seg_table_base,
	output logic [15:0] partition_bound,
	output logic [2:0] cpu_mode
);
	cag_dec_if dec ();
	cag_pkg::cag_mode_type mode;
	logic [2:0] nest;
	logic grant;
	logic local_sel;
	logic wr_go;
	logic psh_write;
	logic [7:0] local_rd;
	logic [7:0] cpu_rdata_reg;
	logic [7:0] seg_lo_reg;
	logic [7:0] seg_hi_reg;
	logic [7:0] fw_lo_reg;
	logic [7:0] fw_hi_reg;
	logic [7:0] psh_upper_reg;
	logic bus_go;
	logic bus_wr_reg;
	logic [7:0] bus_addr_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] bus_rd;
	logic log_en_reg;
	logic clear_pulse;
	logic denied_event;
	logic [15:0] deny_cnt_reg;
	logic [8:0] last_deny_reg;

	// One decision per cycle; the checker sees the live mode and segment rights.
	assign dec.mode = mode;
	assign dec.addr = cpu_addr;
	assign dec.write = cpu_write;
	assign dec.fw_lo = fw_lo_reg;
	assign dec.fw_hi = fw_hi_reg;
	assign dec.seg_rd = seg_rd_ok;
	assign dec.seg_wr = seg_wr_ok;
	assign grant = dec.grant;

	cag_rights u_rights (
		.dec(dec)
	);

	cag_mode_ctrl u_mode (
		.hclk(hclk),
		.hresetn(hresetn),
		.irq_entry(irq_entry),
		.irq_return(irq_return),
		.psh_write(psh_write),
		.psh_mode(cpu_wdata[cag_pkg::PSH_MODE_MSB:cag_pkg::PSH_MODE_LSB]),
		.branch_valid(branch_valid),
		.branch_call(branch_call),
		.branch_target(branch_target),
		.mode(mode),
		.nest(nest)
	);

	// Registers held inside the guard rather than in the resource fabric.
	assign local_sel = cpu_addr == cag_pkg::SFR_PROGRAM_STATUS_HIGH ||
		cag_pkg::grp_of(cpu_addr) == cag_pkg::GRP_SEG ||
		cag_pkg::grp_of(cpu_addr) == cag_pkg::GRP_FW;
	assign wr_go = cpu_valid && cpu_write && grant;
	assign psh_write = wr_go && cpu_addr == cag_pkg::SFR_PROGRAM_STATUS_HIGH;
	assign cpu_denied = cpu_valid && !grant;
	assign cpu_mode = mode;

	// Refused accesses never reach the resources, so a refused write has no effect.
	assign res_valid = cpu_valid && grant && !local_sel;
	assign res_write = cpu_write;
	assign res_addr = cpu_addr;
	assign res_wdata = cpu_wdata;

	// The partition is a constant; no register can move it.
	assign partition_bound = cag_pkg::PART_BOUND;
	assign seg_table_base = {seg_hi_reg, seg_lo_reg};

	// Read view of the locally held registers.
	always_comb begin
		case (cpu_addr)
			cag_pkg::SFR_PROGRAM_STATUS_HIGH: local_rd = {psh_upper_reg[7:3], mode};
			cag_pkg::SFR_SEG_BASE_LO: local_rd = seg_lo_reg;
			cag_pkg::SFR_SEG_BASE_HI: local_rd = seg_hi_reg;
			cag_pkg::SFR_FIREWALL_CONTROL_LOW: local_rd = fw_lo_reg;
			cag_pkg::SFR_FIREWALL_CONTROL_HIGH: local_rd = fw_hi_reg;
			default: local_rd = 8'h00;
		endcase
	end

	// Segment table address; only the base is guarded, the table itself is
	// plain memory whose writes the memory unit checks by segment rights.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seg_lo_reg <= cag_pkg::SFR_RESET;
			seg_hi_reg <= cag_pkg::SFR_RESET;
		end else if (wr_go) begin
			if (cpu_addr == cag_pkg::SFR_SEG_BASE_LO) begin
				seg_lo_reg <= cpu_wdata;
			end
			if (cpu_addr == cag_pkg::SFR_SEG_BASE_HI) begin
				seg_hi_reg <= cpu_wdata;
			end
		end
	end

	// Firewall rights and the spare status bits.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fw_lo_reg <= cag_pkg::SFR_RESET;
			fw_hi_reg <= cag_pkg::SFR_RESET;
			psh_upper_reg <= cag_pkg::SFR_RESET;
		end else if (wr_go) begin
			if (cpu_addr == cag_pkg::SFR_FIREWALL_CONTROL_LOW) begin
				fw_lo_reg <= cpu_wdata;
			end
			if (cpu_addr == cag_pkg::SFR_FIREWALL_CONTROL_HIGH) begin
				fw_hi_reg <= cpu_wdata;
			end
			if (cpu_addr == cag_pkg::SFR_PROGRAM_STATUS_HIGH) begin
				psh_upper_reg <= cpu_wdata;
			end
		end
	end

	// Read data one cycle after the access; a refused read returns zero.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_rdata_reg <= 8'h00;
		end else if (cpu_valid && !cpu_write) begin
			if (!grant) begin
				cpu_rdata_reg <= 8'h00;
			end else if (local_sel) begin
				cpu_rdata_reg <= local_rd;
			end else begin
				cpu_rdata_reg <= res_rdata;
			end
		end
	end
	assign cpu_rdata = cpu_rdata_reg;

	// Bus slave: zero wait states, always OKAY, word registers only.
	assign bus_go = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	always_comb begin
		case (haddr[7:0])
			cag_pkg::REG_CTRL: bus_rd = {31'h00000000, log_en_reg};
			cag_pkg::REG_STATUS: bus_rd = {26'h0000000, nest, mode};
			cag_pkg::REG_DENY_COUNT: bus_rd = {16'h0000, deny_cnt_reg};
			cag_pkg::REG_LAST_DENY: bus_rd = {23'h000000, last_deny_reg};
			default: bus_rd = 32'h00000000;
		endcase
	end

	// Address phase capture; read data are fetched here so they stand in the data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_wr_reg <= 1'b0;
			bus_addr_reg <= 8'h00;
			hrdata_reg <= 32'h00000000;
		end else begin
			bus_wr_reg <= bus_go && hwrite;
			if (bus_go) begin
				bus_addr_reg <= haddr[7:0];
			end
			if (bus_go && !hwrite) begin
				hrdata_reg <= bus_rd;
			end
		end
	end

	// Control register write in the data phase.
	assign clear_pulse = bus_wr_reg && bus_addr_reg == cag_pkg::REG_CTRL &&
		hwdata[cag_pkg::CTRL_CLEAR];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			log_en_reg <= cag_pkg::CTRL_LOG_EN_RESET;
		end else if (bus_wr_reg && bus_addr_reg == cag_pkg::REG_CTRL) begin
			log_en_reg <= hwdata[cag_pkg::CTRL_LOG_EN];
		end
	end

	// Refusal log; a refusal in the clearing cycle is still counted.
	assign denied_event = cpu_denied && log_en_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			deny_cnt_reg <= 16'h0000;
			last_deny_reg <= 9'h000;
		end else begin
			if (denied_event) begin
				deny_cnt_reg <= clear_pulse ? 16'h0001 : deny_cnt_reg + 16'h0001;
				last_deny_reg <= {cpu_write, cpu_addr};
			end else if (clear_pulse) begin
				deny_cnt_reg <= 16'h0000;
			end
		end
	end

	// Checks on the guard's own outputs.
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_refused_read_zero: assert property (
		cpu_valid && !cpu_write && !grant |=> cpu_rdata == 8'h00)
		else $error("refused read returned data");
	a_seg_system_only: assert property (
		cpu_valid && cag_pkg::grp_of(cpu_addr) == cag_pkg::GRP_SEG &&
		mode != cag_pkg::MODE_SYSTEM |-> !grant ##1 seg_table_base == $past(seg_table_base))
		else $error("segmentation register reached outside system mode");
	a_pointer_hidden: assert property (
		cpu_valid && !cpu_write && (cpu_addr == cag_pkg::SFR_SYSMGMT_POINTER_A ||
		cpu_addr == cag_pkg::SFR_SYSMGMT_POINTER_B) |-> !res_valid ##1 cpu_rdata == 8'h00)
		else $error("management pointer was readable");
	a_random_ro: assert property (
		cpu_valid && cpu_write && cpu_addr == cag_pkg::SFR_RANDOM_NUMBER_VALUE |-> !res_valid)
		else $error("random register write passed");
	a_key_hidden: assert property (
		cpu_valid && !cpu_write && (cpu_addr == cag_pkg::SFR_CIPHER_KEY_A ||
		cpu_addr == cag_pkg::SFR_CIPHER_KEY_B) |=> cpu_rdata == 8'h00)
		else $error("cipher key was readable");
	a_cpu_group_open: assert property (
		cpu_valid && cag_pkg::grp_of(cpu_addr) == cag_pkg::GRP_CPU |-> res_valid && !cpu_denied)
		else $error("general register refused");
	a_user_seg_rights: assert property (
		cpu_valid && mode == cag_pkg::MODE_USER && cag_pkg::grp_of(cpu_addr) == cag_pkg::GRP_HW &&
		cpu_addr != cag_pkg::SFR_RANDOM_NUMBER_VALUE && cpu_addr != cag_pkg::SFR_CIPHER_KEY_A &&
		cpu_addr != cag_pkg::SFR_CIPHER_KEY_B |-> grant == (cpu_write ? seg_wr_ok : seg_rd_ok))
		else $error("user access ignored segment rights");
	a_clock_source_select_clos: assert property (
		cpu_valid && !cpu_write && mode == cag_pkg::MODE_CLOS &&
		cpu_addr == cag_pkg::SFR_CLOCK_SOURCE_SELECT |-> res_valid)
		else $error("clock select read refused in contactless mode");
	a_irq_to_system: assert property (
		irq_entry |=> mode == cag_pkg::MODE_SYSTEM && nest != 3'h0)
		else $error("handler entry left mode unchanged");
	a_return_from_interrupt_restore: assert property (
		irq_entry && nest < 3'h4 ##1 irq_return && !irq_entry |=> mode == $past(mode, 2))
		else $error("handler return did not restore mode");
	a_system_entry_vector_entry: assert property (
		branch_valid && branch_target == cag_pkg::SYSTEM_ENTRY_VECTOR && !irq_entry &&
		!irq_return && !psh_write |=> mode == cag_pkg::MODE_SYSTEM)
		else $error("system entry vector did not switch mode");
	a_psh_mode_write: assert property (
		psh_write && !irq_entry && !irq_return && cpu_wdata[2:0] == 3'h4 |=>
		mode == cag_pkg::MODE_USER)
		else $error("status high write did not switch mode");

	// Refusal path and the remaining mode events but the contactless call; a refused write must leave every held
	// register as it was, whatever else the cycle brings.
	a_refused_write_drop: assert property (
		cpu_valid && cpu_write && !grant |-> !res_valid ##1
		fw_lo_reg == $past(fw_lo_reg) && fw_hi_reg == $past(fw_hi_reg) &&
		psh_upper_reg == $past(psh_upper_reg) && seg_table_base == $past(seg_table_base))
		else $error("refused write changed a held register");
	a_psh_readable: assert property (
		cpu_valid && !cpu_write && cpu_addr == cag_pkg::SFR_PROGRAM_STATUS_HIGH &&
		(mode == cag_pkg::MODE_CLOS || mode == cag_pkg::MODE_USER) |-> !cpu_denied)
		else $error("status high read refused");
	a_system_groups: assert property (
		cpu_valid && mode == cag_pkg::MODE_SYSTEM &&
		(cag_pkg::grp_of(cpu_addr) == cag_pkg::GRP_SEG ||
		cag_pkg::grp_of(cpu_addr) == cag_pkg::GRP_FW) |-> !cpu_denied)
		else $error("system mode refused its own group");
	a_seg_base_write: assert property (
		wr_go && cpu_addr == cag_pkg::SFR_SEG_BASE_LO |=>
		seg_table_base[7:0] == $past(cpu_wdata))
		else $error("segment table base write lost");
	a_fw_write_needs: assert property (
		!$stable(fw_lo_reg) || !$stable(fw_hi_reg) |-> $past(wr_go))
		else $error("firewall register changed without a granted write");
	a_special_call: assert property (
		branch_valid && branch_call && branch_target == cag_pkg::USER_CALL_ADDR &&
		!irq_entry && !irq_return && !psh_write |=> mode == cag_pkg::MODE_USER)
		else $error("special call did not switch mode");
	a_cfg_entry: assert property (
		branch_valid && branch_target == cag_pkg::CONFIG_ENTRY_VECTOR && !irq_entry &&
		!irq_return && !psh_write |=> mode == cag_pkg::MODE_BOOT)
		else $error("configuration entry vector did not switch mode");
	a_return_pops: assert property (
		irq_return && !irq_entry && nest != 3'h0 |=> nest == $past(nest) - 3'h1)
		else $error("handler return left the nesting depth");

	c_user_hw_grant: cover property (cpu_valid && mode == cag_pkg::MODE_USER && res_valid);
	c_nested_irq: cover property (irq_entry ##1 irq_entry ##1 irq_return);
	c_system_seg_write: cover property (wr_go && cpu_addr == cag_pkg::SFR_SEG_BASE_LO);
	c_deny_clear: cover property (denied_event && clear_pulse);
	c_test_mode: cover property (mode == cag_pkg::MODE_TEST);
endmodule

// ==== hdl/cag_pkg.sv ====
// Constants, types and decode helpers shared by the access guard files.
package cag_pkg;

	// CPU modes, binary codes written out.
	typedef enum logic [2:0] {
		MODE_BOOT = 3'b000,
		MODE_TEST = 3'b001,
		MODE_CLOS = 3'b010,
		MODE_SYSTEM = 3'b011,
		MODE_USER = 3'b100
	} cag_mode_type;

	// Register groups of the CPU register space.
	typedef enum logic [2:0] {
		GRP_CPU = 3'b000,
		GRP_SYS = 3'b001,
		GRP_SEG = 3'b010,
		GRP_FW = 3'b011,
		GRP_CLOS = 3'b100,
		GRP_HW = 3'b101,
		GRP_NONE = 3'b110
	} cag_group_type;

	// CPU register addresses held or checked by name.
	localparam logic [7:0] SFR_PROGRAM_STATUS_HIGH = 8'h90;
	localparam logic [7:0] SFR_SYSMGMT_POINTER_A = 8'h91;
	localparam logic [7:0] SFR_SYSMGMT_POINTER_B = 8'h92;
	localparam logic [7:0] SFR_SEG_BASE_LO = 8'hA0;
	localparam logic [7:0] SFR_SEG_BASE_HI = 8'hA1;
	localparam logic [7:0] SFR_FIREWALL_CONTROL_LOW = 8'hB0;
	localparam logic [7:0] SFR_FIREWALL_CONTROL_HIGH = 8'hB1;
	localparam logic [7:0] SFR_CLOCK_SOURCE_SELECT = 8'hD0;
	localparam logic [7:0] SFR_RANDOM_NUMBER_VALUE = 8'hD1;
	localparam logic [7:0] SFR_CIPHER_KEY_A = 8'hD2;
	localparam logic [7:0] SFR_CIPHER_KEY_B = 8'hD3;

	// Mode entry addresses and the fixed memory partition boundary.
	localparam logic [15:0] SYSTEM_ENTRY_VECTOR = 16'h0100;
	localparam logic [15:0] CONFIG_ENTRY_VECTOR = 16'h0200;
	localparam logic [15:0] CLOS_CALL_ADDR = 16'h0300;
	localparam logic [15:0] USER_CALL_ADDR = 16'h0400;
	localparam logic [15:0] PART_BOUND = 16'h8000;

	// Program status high layout and reset values.
	localparam int PSH_MODE_LSB = 0;
	localparam int PSH_MODE_MSB = 2;
	localparam logic [7:0] SFR_RESET = 8'h00;
	localparam int STACK_DEPTH = 4;

	// Bus register byte offsets and fields.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_DENY_COUNT = 8'h08;
	localparam logic [7:0] REG_LAST_DENY = 8'h0C;
	localparam int CTRL_LOG_EN = 0;
	localparam int CTRL_CLEAR = 1;
	localparam logic CTRL_LOG_EN_RESET = 1'b1;

	// Group of a CPU register address.
	function automatic cag_group_type grp_of(input logic [7:0] a);
		case (a[7:4])
			4'h8: grp_of = GRP_CPU;
			4'h9: grp_of = GRP_SYS;
			4'hA: grp_of = GRP_SEG;
			4'hB: grp_of = GRP_FW;
			4'hC: grp_of = GRP_CLOS;
			4'hD, 4'hE, 4'hF: grp_of = GRP_HW;
			default: grp_of = GRP_NONE;
		endcase
	endfunction

endpackage

// ==== hdl/cag_dec_if.sv ====
// Carrier for one access decision between the guard and its rights checker.
`timescale 1ns/1ns
interface cag_dec_if;
	cag_pkg::cag_mode_type mode;
	logic [7:0] addr;
	logic write;
	logic [7:0] fw_lo;
	logic [7:0] fw_hi;
	logic seg_rd;
	logic seg_wr;
	logic grant;
	modport req(output mode, output addr, output write, output fw_lo, output fw_hi,
		output seg_rd, output seg_wr, input grant);
	modport chk(input mode, input addr, input write, input fw_lo, input fw_hi,
		input seg_rd, input seg_wr, output grant);
endinterface

// ==== hdl/cag_rights.sv ====
// Combinational access decision from mode, register group and segment rights.
`timescale 1ns/1ns
module cag_rights (
	cag_dec_if.chk dec
);
	logic rd_ok;
	logic wr_ok;
	logic priv;

	// The decision is purely combinational so a refused access never half-happens.
	always_comb begin
		priv = dec.mode == cag_pkg::MODE_BOOT || dec.mode == cag_pkg::MODE_TEST ||
			dec.mode == cag_pkg::MODE_SYSTEM;
		rd_ok = 1'b0;
		wr_ok = 1'b0;
		case (cag_pkg::grp_of(dec.addr))
			cag_pkg::GRP_CPU: begin
				rd_ok = 1'b1;
				wr_ok = 1'b1;
			end
			cag_pkg::GRP_SYS: begin
				rd_ok = priv;
				wr_ok = priv;
				if (dec.addr == cag_pkg::SFR_PROGRAM_STATUS_HIGH &&
					(dec.mode == cag_pkg::MODE_CLOS || dec.mode == cag_pkg::MODE_USER)) begin
					rd_ok = 1'b1;
				end
				if (dec.addr == cag_pkg::SFR_SYSMGMT_POINTER_A ||
					dec.addr == cag_pkg::SFR_SYSMGMT_POINTER_B) begin
					rd_ok = 1'b0;
				end
			end
			cag_pkg::GRP_SEG: begin
				rd_ok = dec.mode == cag_pkg::MODE_SYSTEM;
				wr_ok = dec.mode == cag_pkg::MODE_SYSTEM;
			end
			cag_pkg::GRP_FW: begin
				rd_ok = priv || dec.mode == cag_pkg::MODE_CLOS;
				wr_ok = priv;
			end
			cag_pkg::GRP_CLOS: begin
				rd_ok = priv && dec.mode != cag_pkg::MODE_SYSTEM || dec.mode == cag_pkg::MODE_CLOS;
				wr_ok = rd_ok;
			end
			cag_pkg::GRP_HW: begin
				case (dec.mode)
					cag_pkg::MODE_BOOT, cag_pkg::MODE_TEST, cag_pkg::MODE_SYSTEM: begin
						rd_ok = 1'b1;
						wr_ok = 1'b1;
					end
					cag_pkg::MODE_CLOS: begin
						rd_ok = dec.fw_lo[dec.addr[2:0]] ||
							dec.addr == cag_pkg::SFR_CLOCK_SOURCE_SELECT;
						wr_ok = dec.fw_hi[dec.addr[2:0]];
					end
					cag_pkg::MODE_USER: begin
						rd_ok = dec.seg_rd;
						wr_ok = dec.seg_wr;
					end
					default: begin
						rd_ok = 1'b0;
						wr_ok = 1'b0;
					end
				endcase
				if (dec.addr == cag_pkg::SFR_RANDOM_NUMBER_VALUE) begin
					wr_ok = 1'b0;
				end
				if (dec.addr == cag_pkg::SFR_CIPHER_KEY_A || dec.addr == cag_pkg::SFR_CIPHER_KEY_B) begin
					rd_ok = 1'b0;
				end
			end
			default: begin
				rd_ok = 1'b0;
				wr_ok = 1'b0;
			end
		endcase
		dec.grant = dec.write ? wr_ok : rd_ok;
	end
endmodule

// ==== hdl/cag_mode_ctrl.sv ====
// CPU mode register with its handler-entry save stack.
`timescale 1ns/1ns
module cag_mode_ctrl (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic irq_entry,
	input wire logic irq_return,
	input wire logic psh_write,
	input wire logic [2:0] psh_mode,
	input wire logic branch_valid,
	input wire logic branch_call,
	input wire logic [15:0] branch_target,
	output cag_pkg::cag_mode_type mode,
	output logic [2:0] nest
);
	cag_pkg::cag_mode_type mode_reg;
	cag_pkg::cag_mode_type stack_reg [cag_pkg::STACK_DEPTH];
	logic [2:0] nest_reg;
	logic [1:0] top;

	assign mode = mode_reg;
	assign nest = nest_reg;
	assign top = nest_reg[1:0] - 2'h1;

	// Event priority: handler entry, then return, then a status write, then a branch.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_reg <= cag_pkg::MODE_BOOT;
		end else if (irq_entry) begin
			mode_reg <= cag_pkg::MODE_SYSTEM;
		end else if (irq_return && nest_reg != 3'h0) begin
			mode_reg <= stack_reg[top];
		end else if (psh_write && psh_mode <= 3'h4) begin
			mode_reg <= cag_pkg::cag_mode_type'(psh_mode);
		end else if (branch_valid && branch_target == cag_pkg::SYSTEM_ENTRY_VECTOR) begin
			mode_reg <= cag_pkg::MODE_SYSTEM;
		end else if (branch_valid && branch_target == cag_pkg::CONFIG_ENTRY_VECTOR) begin
			mode_reg <= cag_pkg::MODE_BOOT;
		end else if (branch_valid && branch_call && branch_target == cag_pkg::CLOS_CALL_ADDR) begin
			mode_reg <= cag_pkg::MODE_CLOS;
		end else if (branch_valid && branch_call && branch_target == cag_pkg::USER_CALL_ADDR) begin
			mode_reg <= cag_pkg::MODE_USER;
		end
	end

	// Saved modes; a full stack overwrites its top entry rather than losing the count.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nest_reg <= 3'h0;
			for (int i = 0; i < cag_pkg::STACK_DEPTH; i++) begin
				stack_reg[i] <= cag_pkg::MODE_BOOT;
			end
		end else if (irq_entry) begin
			if (nest_reg == 3'h4) begin
				stack_reg[2'h3] <= mode_reg;
			end else begin
				stack_reg[nest_reg[1:0]] <= mode_reg;
				nest_reg <= nest_reg + 3'h1;
			end
		end else if (irq_return && nest_reg != 3'h0) begin
			nest_reg <= nest_reg - 3'h1;
		end
	end
endmodule

// ==== tb/cag_res_model.sv ====
// Behavioural register resources that answer the guard's forwarded accesses.
`timescale 1ns/1ns
module cag_res_model (
	input wire logic hclk,
	input wire logic res_valid,
	input wire logic res_write,
	input wire logic [7:0] res_addr,
	input wire logic [7:0] res_wdata,
	output logic [7:0] res_rdata
);
	logic [7:0] mem [0:255];
	logic [7:0] last_reg;
	// Each location starts at its address xor a pattern, so a wrong address shows at once.
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h3C;
		end
		last_reg = 8'h00;
	end
	// Writes land at the edge that takes them; the last read value is kept for the idle bus.
	always @(posedge hclk) begin
		if (res_valid && res_write) begin
			mem[res_addr] <= res_wdata;
		end
		if (res_valid && !res_write) begin
			last_reg <= mem[res_addr];
		end
	end
	// Outside a read the bus shows the inverse of the last value, so stale data never passes.
	assign res_rdata = (res_valid && !res_write) ? mem[res_addr] : ~last_reg;
endmodule

// ==== tb/cag_access_guard_tb.sv ====
// Self-checking bench for the register access guard.
`timescale 1ns/1ns
module cag_access_guard_tb;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic cpu_valid, cpu_write, cpu_denied, seg_rd_ok, seg_wr_ok;
	logic irq_entry, irq_return, branch_valid, branch_call, res_valid, res_write;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize, cpu_mode;
	logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, res_addr, res_wdata, res_rdata;
	logic [15:0] branch_target, seg_table_base, partition_bound;
	int error_cnt, checked, exp_deny;

	// The single slave's ready is the bus ready.
	assign hready = hreadyout;

	cag_access_guard cag_access_guard_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.cpu_valid(cpu_valid), .cpu_write(cpu_write), .cpu_addr(cpu_addr),
		.cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_denied(cpu_denied),
		.seg_rd_ok(seg_rd_ok), .seg_wr_ok(seg_wr_ok), .irq_entry(irq_entry),
		.irq_return(irq_return), .branch_valid(branch_valid), .branch_call(branch_call),
		.branch_target(branch_target), .res_valid(res_valid), .res_write(res_write),
		.res_addr(res_addr), .res_wdata(res_wdata), .res_rdata(res_rdata),
		.seg_table_base(seg_table_base), .partition_bound(partition_bound),
		.cpu_mode(cpu_mode));

	cag_res_model cag_res_model_i (.hclk(hclk), .res_valid(res_valid),
		.res_write(res_write), .res_addr(res_addr), .res_wdata(res_wdata),
		.res_rdata(res_rdata));

	// Clock of 8 ns.
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	task automatic print_verdict;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Bounded wait for hready; a hung bus ends the run.
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		if (hreadyout !== 1'b1) begin
			error_cnt++;
			print_verdict();
		end
	endtask

	// One single-word bus transfer; read data is taken at the end of the data phase.
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h000000, a};
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	// One CPU register access; granted reads from D0 up are checked against the model's pattern.
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic den);
		@(posedge hclk);
		cpu_valid <= 1'b1;
		cpu_write <= w;
		cpu_addr <= a;
		cpu_wdata <= d;
		#1;
		chk("cpu_denied", {31'h0, den}, {31'h0, cpu_denied});
		exp_deny += int'(den);
		@(posedge hclk);
		cpu_valid <= 1'b0;
		#1;
		if (!w && (den || a >= 8'hD0)) begin
			chk("cpu_rdata", den ? 32'h0 : {24'h0, a ^ 8'h3C}, {24'h0, cpu_rdata});
		end
	endtask

	// Mode event pulse: 1 entry, 2 return, 3 branch, 4 call; mode checked after it lands.
	task automatic ev(input int kind, input logic [15:0] t, input logic [2:0] m);
		@(posedge hclk);
		irq_entry <= (kind == 1);
		irq_return <= (kind == 2);
		branch_valid <= (kind >= 3);
		branch_call <= (kind == 4);
		branch_target <= t;
		@(posedge hclk);
		irq_entry <= 1'b0;
		irq_return <= 1'b0;
		branch_valid <= 1'b0;
		#1;
		chk("cpu_mode", {29'h0, m}, {29'h0, cpu_mode});
	endtask

	task automatic t_reset;
		chk("cpu_mode", 32'h0, {29'h0, cpu_mode});
		chk("seg_table_base", 32'h0, {16'h0, seg_table_base});
		chk("partition_bound", {16'h0, cag_pkg::PART_BOUND}, {16'h0, partition_bound});
		ahb(1'b0, cag_pkg::REG_CTRL, 32'h0);
		chk("ctrl", {31'h0, cag_pkg::CTRL_LOG_EN_RESET}, rd);
	endtask

	task automatic t_modes;
		ev(3, cag_pkg::SYSTEM_ENTRY_VECTOR, cag_pkg::MODE_SYSTEM);
		acc(1'b1, cag_pkg::SFR_SEG_BASE_LO, 8'h55, 1'b0);
		acc(1'b1, cag_pkg::SFR_SEG_BASE_HI, 8'h12, 1'b0);
		chk("seg_table_base", 32'h1255, {16'h0, seg_table_base});
		ev(3, cag_pkg::CONFIG_ENTRY_VECTOR, cag_pkg::MODE_BOOT);
		acc(1'b1, cag_pkg::SFR_SEG_BASE_LO, 8'hEE, 1'b1);
		chk("seg_table_base", 32'h1255, {16'h0, seg_table_base});
		ev(4, cag_pkg::CLOS_CALL_ADDR, cag_pkg::MODE_CLOS);
		acc(1'b0, cag_pkg::SFR_CLOCK_SOURCE_SELECT, 8'h00, 1'b0);
		acc(1'b0, 8'hD5, 8'h00, 1'b1);
		ev(4, cag_pkg::USER_CALL_ADDR, cag_pkg::MODE_USER);
	endtask

	task automatic t_user;
		acc(1'b1, 8'h85, 8'h5A, 1'b0);
		acc(1'b0, 8'h85, 8'h00, 1'b0);
		acc(1'b0, cag_pkg::SFR_PROGRAM_STATUS_HIGH, 8'h00, 1'b0);
		seg_rd_ok <= 1'b0;
		acc(1'b0, 8'hD5, 8'h00, 1'b1);
		seg_rd_ok <= 1'b1;
		acc(1'b0, 8'hD5, 8'h00, 1'b0);
		seg_wr_ok <= 1'b1;
		acc(1'b1, 8'hD6, 8'hAA, 1'b0);
		chk("res D6", 32'hAA, {24'h0, cag_res_model_i.mem[8'hD6]});
		seg_wr_ok <= 1'b0;
		acc(1'b1, 8'hD7, 8'h11, 1'b1);
		chk("res D7", {24'h0, 8'hD7 ^ 8'h3C}, {24'h0, cag_res_model_i.mem[8'hD7]});
		acc(1'b1, cag_pkg::SFR_SEG_BASE_LO, 8'h00, 1'b1);
		chk("seg_table_base", 32'h1255, {16'h0, seg_table_base});
		ev(1, 16'h0000, cag_pkg::MODE_SYSTEM);
		ev(2, 16'h0000, cag_pkg::MODE_USER);
	endtask

	task automatic t_system;
		ev(3, cag_pkg::SYSTEM_ENTRY_VECTOR, cag_pkg::MODE_SYSTEM);
		acc(1'b0, cag_pkg::SFR_SYSMGMT_POINTER_A, 8'h00, 1'b1);
		acc(1'b0, cag_pkg::SFR_SYSMGMT_POINTER_B, 8'h00, 1'b1);
		acc(1'b1, cag_pkg::SFR_RANDOM_NUMBER_VALUE, 8'h77, 1'b1);
		chk("res D1", {24'h0, 8'hD1 ^ 8'h3C}, {24'h0, cag_res_model_i.mem[8'hD1]});
		acc(1'b0, cag_pkg::SFR_CIPHER_KEY_A, 8'h00, 1'b1);
		acc(1'b0, cag_pkg::SFR_CIPHER_KEY_B, 8'h00, 1'b1);
		acc(1'b1, cag_pkg::SFR_CIPHER_KEY_A, 8'h99, 1'b0);
		acc(1'b1, cag_pkg::SFR_FIREWALL_CONTROL_LOW, 8'h20, 1'b0);
		ev(4, cag_pkg::CLOS_CALL_ADDR, cag_pkg::MODE_CLOS);
		acc(1'b0, 8'hD5, 8'h00, 1'b0);
		acc(1'b1, cag_pkg::SFR_PROGRAM_STATUS_HIGH, 8'h01, 1'b1);
		ev(3, cag_pkg::SYSTEM_ENTRY_VECTOR, cag_pkg::MODE_SYSTEM);
		acc(1'b1, cag_pkg::SFR_PROGRAM_STATUS_HIGH, 8'h01, 1'b0);
		chk("cpu_mode", {29'h0, cag_pkg::MODE_TEST}, {29'h0, cpu_mode});
		ev(3, cag_pkg::SYSTEM_ENTRY_VECTOR, cag_pkg::MODE_SYSTEM);
		acc(1'b1, cag_pkg::SFR_PROGRAM_STATUS_HIGH, 8'h04, 1'b0);
		#8;
		chk("cpu_mode", {29'h0, cag_pkg::MODE_USER}, {29'h0, cpu_mode});
		acc(1'b1, cag_pkg::SFR_PROGRAM_STATUS_HIGH, 8'h03, 1'b1);
		#8;
		chk("cpu_mode", {29'h0, cag_pkg::MODE_USER}, {29'h0, cpu_mode});
	endtask

	task automatic t_bus;
		ahb(1'b0, cag_pkg::REG_STATUS, 32'h0);
		chk("status", {29'h0, cag_pkg::MODE_USER}, rd);
		ahb(1'b0, cag_pkg::REG_DENY_COUNT, 32'h0);
		chk("deny count", exp_deny, rd);
		ahb(1'b0, cag_pkg::REG_LAST_DENY, 32'h0);
		chk("last deny", 32'h190, rd);
		ahb(1'b1, cag_pkg::REG_CTRL, 32'h3);
		ahb(1'b0, cag_pkg::REG_DENY_COUNT, 32'h0);
		chk("deny count", 32'h0, rd);
		ahb(1'b0, 8'h10, 32'h0);
		chk("unmapped", 32'h0, rd);
	endtask

	// Main sequence: every input set at time zero, reset held ten cycles.
	initial begin
		hresetn = 1'b0;
		{hsel, hwrite, cpu_valid, cpu_write, irq_entry, irq_return} = 6'h00;
		{branch_valid, branch_call, seg_rd_ok, seg_wr_ok} = 4'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		cpu_addr = 8'h00;
		cpu_wdata = 8'h00;
		branch_target = 16'h0000;
		error_cnt = 0;
		checked = 0;
		exp_deny = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		#1;
		t_reset();
		t_modes();
		t_user();
		t_system();
		t_bus();
		print_verdict();
	end
endmodule
